// ==== pkg/pbw_pkg.sv ====
package pbw_pkg;

   // Access classes presented by the CPU bus with each request
   typedef enum logic [2:0] {
      PBW_PLAIN  = 3'h0,
      PBW_CNT_RD = 3'h1,
      PBW_CMP_RD = 3'h2,
      PBW_CMP_WR = 3'h3,
      PBW_WDT_WR = 3'h4,
      PBW_RTO_WR = 3'h5,
      PBW_ADC_RD = 3'h6,
      PBW_I2C_RD = 3'h7
   } pbw_class_e;

   // Wait setting layout
   localparam int unsigned WAIT_I_MSB = 7;
   localparam int unsigned WAIT_I_LSB = 4;
   localparam int unsigned WAIT_J_MSB = 3;
   localparam int unsigned WAIT_J_LSB = 0;

   // Clock count terms: 3 + i + j + (2 + j) * k
   localparam logic [4:0] BASE_CLKS   = 5'h03;
   localparam logic [4:0] J_MULT_BASE = 5'h02;

   // Per-register wait factors
   localparam logic [2:0] K_NONE     = 3'h0;
   localparam logic [2:0] K_READ_LO  = 3'h1;
   localparam logic [2:0] K_READ_HI  = 3'h2;
   localparam logic [2:0] K_I2C      = 3'h1;
   localparam logic [2:0] K_CMP_LO   = 3'h3;
   localparam logic [2:0] K_CMP_HI   = 3'h4;
   localparam logic [2:0] K_WDT      = 3'h3;
   localparam logic [2:0] K_RTO      = 3'h1;

   // Reset values
   localparam logic [4:0] CNT_RST = 5'h00;

endpackage

// ==== logic/pbw_bridge.sv ====
`timescale 1ns/1ns
module pbw_bridge (
   // Clock, reset, enable
   input  wire logic               MCLK,
   input  wire logic               RST_B,
   input  wire logic               CE,
   // CPU bus request
   input  wire logic               ACC_REQ,
   input  wire pbw_pkg::pbw_class_e ACC_CLASS,
   input  wire logic [7:0]         SYS_WAIT_SETTING,
   // Peripheral side status
   input  wire logic               PERIPH_LATE_PHASE,
   input  wire logic               WDT_RUNNING,
   input  wire logic               RT_OUTPUT_ENABLE_BIT,
   input  wire logic               CLK_SUB_MAIN_STOPPED,
   input  wire logic               CLK_INTERNAL_OSC,
   // CPU bus answer
   output logic                    CPU_WAIT,
   output logic                    ACC_DONE,
   output logic                    ACC_HUNG
);
   import pbw_pkg::*;

   logic       accept;
   logic       listed;
   logic       term_i;
   logic       term_j;
   logic [2:0] k_d;
   logic [4:0] total_d;
   logic [4:0] cnt_q;
   logic       stall_q;
   logic       done_q;
   logic       hung_q;
   logic       prev_cmp_wr_q;

   // Request taken only when idle; requests during a stall are ignored
   assign accept = CE && ACC_REQ && !stall_q;
   assign listed = (ACC_CLASS != PBW_PLAIN);

   // Wait setting terms, nibble nonzero counts as one
   assign term_i = |SYS_WAIT_SETTING[WAIT_I_MSB:WAIT_I_LSB];
   assign term_j = |SYS_WAIT_SETTING[WAIT_J_MSB:WAIT_J_LSB];

   // Per-register wait factor selection
   always_comb begin
      unique case (ACC_CLASS)
         PBW_CNT_RD, PBW_CMP_RD, PBW_ADC_RD: begin
            k_d = PERIPH_LATE_PHASE ? K_READ_HI : K_READ_LO;
         end
         PBW_I2C_RD: begin
            k_d = K_I2C;
         end
         PBW_CMP_WR: begin
            if (prev_cmp_wr_q) begin
               k_d = PERIPH_LATE_PHASE ? K_CMP_HI : K_CMP_LO;
            end else begin
               k_d = K_NONE;
            end
         end
         PBW_WDT_WR: begin
            k_d = WDT_RUNNING ? K_WDT : K_NONE;
         end
         PBW_RTO_WR: begin
            k_d = RT_OUTPUT_ENABLE_BIT ? K_NONE : K_RTO;
         end
         PBW_PLAIN: begin
            k_d = K_NONE;
         end
      endcase
   end

   // Total access clocks, extra factor on top of the setting
   assign total_d = 5'(BASE_CLKS + {4'h0, term_i} + {4'h0, term_j}
                    + 5'((J_MULT_BASE + {4'h0, term_j}) * {2'h0, k_d}));

   // Stall length counter; CPU waits until the count has run out
   always_ff @(posedge MCLK or negedge RST_B) begin
      if (!RST_B) begin
         cnt_q <= CNT_RST;
      end else if (accept) begin
         cnt_q <= 5'(total_d - 5'h01);
      end else if (CE && stall_q && !hung_q && cnt_q != CNT_RST) begin
         cnt_q <= 5'(cnt_q - 5'h01);
      end
   end

   // Stall flag held from accept until the cycle after done
   always_ff @(posedge MCLK or negedge RST_B) begin
      if (!RST_B) begin
         stall_q <= 1'b0;
      end else if (accept) begin
         stall_q <= 1'b1;
      end else if (CE && done_q) begin
         stall_q <= 1'b0;
      end
   end

   // Completion pulse in the last clock of the access; raised while two
   // counts remain so the request cycle counts as the first clock
   always_ff @(posedge MCLK or negedge RST_B) begin
      if (!RST_B) begin
         done_q <= 1'b0;
      end else if (CE) begin
         done_q <= stall_q && !hung_q && !done_q
                   && cnt_q == 5'h02;
      end
   end

   // Listed access under a prohibited clock locks until reset
   always_ff @(posedge MCLK or negedge RST_B) begin
      if (!RST_B) begin
         hung_q <= 1'b0;
      end else if (accept && listed
                   && (CLK_SUB_MAIN_STOPPED || CLK_INTERNAL_OSC)) begin
         hung_q <= 1'b1;
      end
   end

   // Remembers whether the last access was a compare write
   always_ff @(posedge MCLK or negedge RST_B) begin
      if (!RST_B) begin
         prev_cmp_wr_q <= 1'b0;
      end else if (accept) begin
         prev_cmp_wr_q <= (ACC_CLASS == PBW_CMP_WR);
      end
   end

   // Outputs straight from flip-flops
   assign CPU_WAIT = stall_q;
   assign ACC_DONE = done_q;
   assign ACC_HUNG = hung_q;

   // Helper: expected total and observed stall length
   logic [4:0] exp_q;
   logic [4:0] len_q;
   always_ff @(posedge MCLK or negedge RST_B) begin
      if (!RST_B) begin
         exp_q <= CNT_RST;
         len_q <= CNT_RST;
      end else if (accept) begin
         exp_q <= total_d;
         len_q <= CNT_RST;
      end else if (CE && stall_q && len_q != 5'h1f) begin
         len_q <= 5'(len_q + 5'h01);
      end
   end

   property p_stall_on_accept;
      @(posedge MCLK) disable iff (!RST_B)
      accept |=> CPU_WAIT;
   endproperty
   a_stall_on_accept: assert property (p_stall_on_accept)
      else $error("CPU not stalled after accepted access");

   property p_release;
      @(posedge MCLK) disable iff (!RST_B)
      ACC_DONE && CE |=> !CPU_WAIT && !ACC_DONE;
   endproperty
   a_release: assert property (p_release)
      else $error("Stall not released right after done");

   property p_length;
      @(posedge MCLK) disable iff (!RST_B)
      ACC_DONE |-> len_q == 5'(exp_q - 5'h02);
   endproperty
   a_length: assert property (p_length)
      else $error("Access length differs from computed count");

   property p_base;
      @(posedge MCLK) disable iff (!RST_B)
      accept && ACC_CLASS == PBW_PLAIN && SYS_WAIT_SETTING == 8'h00
         |-> ##2 ACC_DONE;
   endproperty
   a_base: assert property (p_base)
      else $error("Plain access not done in three clocks");

   property p_ij;
      @(posedge MCLK) disable iff (!RST_B)
      accept && ACC_CLASS == PBW_PLAIN && SYS_WAIT_SETTING == 8'h11
         |-> !ACC_DONE [*4] ##1 ACC_DONE;
   endproperty
   a_ij: assert property (p_ij)
      else $error("Wait setting terms not added");

   property p_read_k;
      @(posedge MCLK) disable iff (!RST_B)
      accept && ACC_CLASS == PBW_CNT_RD && !PERIPH_LATE_PHASE
         && SYS_WAIT_SETTING == 8'h00 |-> ##4 ACC_DONE;
   endproperty
   a_read_k: assert property (p_read_k)
      else $error("Counter read not five clocks");

   property p_cmp_first;
      @(posedge MCLK) disable iff (!RST_B)
      accept && ACC_CLASS == PBW_CMP_WR && !prev_cmp_wr_q
         && SYS_WAIT_SETTING == 8'h00 |-> ##2 ACC_DONE;
   endproperty
   a_cmp_first: assert property (p_cmp_first)
      else $error("First compare write was stretched");

   property p_wdt;
      @(posedge MCLK) disable iff (!RST_B)
      accept && ACC_CLASS == PBW_WDT_WR && WDT_RUNNING
         && SYS_WAIT_SETTING == 8'h00 |-> ##8 ACC_DONE;
   endproperty
   a_wdt: assert property (p_wdt)
      else $error("Watchdog write not nine clocks");

   property p_rto;
      @(posedge MCLK) disable iff (!RST_B)
      accept && ACC_CLASS == PBW_RTO_WR && !RT_OUTPUT_ENABLE_BIT
         && SYS_WAIT_SETTING == 8'h00 |-> ##4 ACC_DONE;
   endproperty
   a_rto: assert property (p_rto)
      else $error("Realtime buffer write not five clocks");

   property p_hang;
      @(posedge MCLK) disable iff (!RST_B)
      ACC_HUNG |=> ACC_HUNG && CPU_WAIT && !ACC_DONE;
   endproperty
   a_hang: assert property (p_hang)
      else $error("Locked stall was released without reset");

endmodule

// ==== test/pbw_cpu_model.sv ====
`timescale 1ns/1ns
module pbw_cpu_model (
   // Clock
   input  wire logic           MCLK,
   // Request towards the bridge
   output pbw_pkg::pbw_class_e ACC_CLASS,
   output logic                ACC_REQ,
   output logic [7:0]          SYS_WAIT_SETTING,
   // Answer from the bridge
   input  wire logic           CPU_WAIT,
   input  wire logic           ACC_DONE
);
   import pbw_pkg::*;
   // Idle bus at time zero
   initial begin
      ACC_REQ = 1'b0;
      ACC_CLASS = PBW_PLAIN;
      SYS_WAIT_SETTING = 8'h00;
   end
   // One access by class only, never into reserved space
   // Returns clocks seen, or 0 on a hang or a broken answer
   task automatic access(input pbw_class_e c, input logic [7:0] w,
                         output int n);
      n = 1;
      ACC_CLASS = c;
      ACC_REQ = 1'b1;
      SYS_WAIT_SETTING = w;
      @(posedge MCLK) #1;
      ACC_REQ = 1'b0;
      ACC_CLASS = pbw_class_e'(~c); // Released lines stop showing old value
      SYS_WAIT_SETTING = ~w;
      while (ACC_DONE !== 1'b1 && n < 40) begin
         @(posedge MCLK) #1;
         n++;
      end
      // Done must arrive while stalled, stall drops one cycle later
      if (n >= 40 || CPU_WAIT !== 1'b1) n = 0;
      else begin
         @(posedge MCLK) #1;
         n = (CPU_WAIT === 1'b0 && ACC_DONE === 1'b0) ? n + 1 : 0;
      end
   endtask
endmodule

// ==== test/test_pbw_bridge.sv ====
`timescale 1ns/1ns
module test_pbw_bridge;
   import pbw_pkg::*;
   logic       MCLK, RST_B, CE, PERIPH_LATE_PHASE, WDT_RUNNING;
   logic       RT_OUTPUT_ENABLE_BIT, CLK_SUB_MAIN_STOPPED, CLK_INTERNAL_OSC;
   logic       ACC_REQ, CPU_WAIT, ACC_DONE, ACC_HUNG;
   logic [7:0] SYS_WAIT_SETTING;
   pbw_class_e ACC_CLASS;
   int         num_errors = 0;
   int         tests_run = 0;
   // Bridge and the CPU that talks to it
   pbw_bridge dut (.MCLK(MCLK), .RST_B(RST_B), .CE(CE), .ACC_REQ(ACC_REQ),
      .ACC_CLASS(ACC_CLASS), .SYS_WAIT_SETTING(SYS_WAIT_SETTING),
      .PERIPH_LATE_PHASE(PERIPH_LATE_PHASE), .WDT_RUNNING(WDT_RUNNING),
      .RT_OUTPUT_ENABLE_BIT(RT_OUTPUT_ENABLE_BIT),
      .CLK_SUB_MAIN_STOPPED(CLK_SUB_MAIN_STOPPED),
      .CLK_INTERNAL_OSC(CLK_INTERNAL_OSC), .CPU_WAIT(CPU_WAIT),
      .ACC_DONE(ACC_DONE), .ACC_HUNG(ACC_HUNG));
   pbw_cpu_model cpu (.MCLK(MCLK), .ACC_CLASS(ACC_CLASS), .ACC_REQ(ACC_REQ),
      .SYS_WAIT_SETTING(SYS_WAIT_SETTING), .CPU_WAIT(CPU_WAIT),
      .ACC_DONE(ACC_DONE));
   // Compare and count
   task automatic check(input string what, input int exp, input int got);
      tests_run++;
      if (got != exp) begin
         num_errors++;
         $display("wrong value %s expected %0d seen %0d", what, exp, got);
      end
   endtask
   // One access, length against 3 + i + j + (2 + j) * k
   task automatic run(input pbw_class_e c, input logic [7:0] w,
                      input int i, input int j, input int k);
      int n;
      cpu.access(c, w, n);
      check(c.name(), 3 + i + j + (2 + j) * k, n);
      // A hang or a broken answer ends the run
      if (n == 0) begin
         wrap_up();
      end
   endtask
   // Unlisted accesses, wait setting nibbles only
   task automatic plain_counts();
      run(PBW_PLAIN, 8'h00, 0, 0, 0);
      run(PBW_PLAIN, 8'h70, 1, 0, 0);
      run(PBW_PLAIN, 8'h08, 0, 1, 0);
      run(PBW_PLAIN, 8'hF1, 1, 1, 0);
      run(PBW_PLAIN, 8'h11, 1, 1, 0);
   endtask
   // Counter and converter reads in both phases, compare read early only, I2C read late only
   task automatic read_counts();
      run(PBW_CNT_RD, 8'h00, 0, 0, 1);
      run(PBW_CMP_RD, 8'h01, 0, 1, 1);
      run(PBW_ADC_RD, 8'h10, 1, 0, 1);
      PERIPH_LATE_PHASE = 1'b1;
      run(PBW_CNT_RD, 8'h00, 0, 0, 2);
      run(PBW_ADC_RD, 8'h11, 1, 1, 2);
      run(PBW_I2C_RD, 8'h11, 1, 1, 1);
   endtask
   // First compare write is free, back-to-back ones are not
   task automatic compare_writes();
      PERIPH_LATE_PHASE = 1'b0;
      run(PBW_CMP_WR, 8'h00, 0, 0, 0);
      run(PBW_CMP_WR, 8'h00, 0, 0, 3);
      PERIPH_LATE_PHASE = 1'b1;
      run(PBW_CMP_WR, 8'h01, 0, 1, 4);
      run(PBW_PLAIN, 8'h00, 0, 0, 0);
      run(PBW_CMP_WR, 8'h00, 0, 0, 0);
   endtask
   // Watchdog and realtime buffer writes depend on unit state
   task automatic state_writes();
      WDT_RUNNING = 1'b1;
      run(PBW_WDT_WR, 8'h11, 1, 1, 3);
      run(PBW_WDT_WR, 8'h00, 0, 0, 3);
      WDT_RUNNING = 1'b0;
      run(PBW_WDT_WR, 8'h00, 0, 0, 0);
      run(PBW_RTO_WR, 8'h00, 0, 0, 1);
      RT_OUTPUT_ENABLE_BIT = 1'b1;
      run(PBW_RTO_WR, 8'h00, 0, 0, 0);
   endtask
   // Requests are ignored while the clock enable is low
   task automatic ce_freeze();
      int n;
      CE = 1'b0;
      cpu.access(PBW_PLAIN, 8'h00, n);
      check("frozen count", 0, n);
      check("frozen wait", 0, int'(CPU_WAIT !== 1'b0));
      CE = 1'b1;
   endtask
   // Listed access on a forbidden clock hangs until reset
   task automatic lock_hold(input logic sub);
      int n;
      int seen;
      CLK_SUB_MAIN_STOPPED = sub;
      CLK_INTERNAL_OSC = ~sub;
      cpu.access(PBW_I2C_RD, 8'h00, n);
      check("hung count", 0, n);
      seen = int'({ACC_HUNG, CPU_WAIT} === 2'b11);
      check("hung", 1, seen);
      CLK_SUB_MAIN_STOPPED = 1'b0;
      CLK_INTERNAL_OSC = 1'b0;
      RST_B = 1'b0;
      @(posedge MCLK) #1;
      RST_B = 1'b1;
      seen = int'({ACC_HUNG, CPU_WAIT} === 2'b00);
      check("released", 1, seen);
      run(PBW_PLAIN, 8'h00, 0, 0, 0);
   endtask
   // Report and end
   task automatic wrap_up();
      $display("checks %0d errors %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // Clock
   initial begin
      MCLK = 1'b0;
      forever #25 MCLK = ~MCLK;
   end
   // Main sequence
   initial begin
      RST_B = 1'b0;
      CE = 1'b1;
      PERIPH_LATE_PHASE = 1'b0;
      WDT_RUNNING = 1'b0;
      RT_OUTPUT_ENABLE_BIT = 1'b0;
      CLK_SUB_MAIN_STOPPED = 1'b0;
      CLK_INTERNAL_OSC = 1'b0;
      repeat (5) @(posedge MCLK);
      #1;
      RST_B = 1'b1;
      plain_counts();
      read_counts();
      compare_writes();
      state_writes();
      ce_freeze();
      lock_hold(1'b1);
      lock_hold(1'b0);
      wrap_up();
   end
endmodule
